/* File: spc_ctrl.sv */
// Operation
// - Byte arriving over unread byte sets overflow, except in reserved modes
// - Slave: release bit zero holds clock low
// - Modes 1111, 1110: slave with start/stop interrupts
// - 1011 firmware master; 1000 hardware master clock
// - Mode 0111: plain slave, no start/stop interrupts
//
// Register access over APB and the register addresses were chosen for this implementation.
`default_nettype none
module spc_ctrl
  import spc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive path from the shift logic.
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        start_seen,
  input  wire logic        stop_seen,
  // Firmware master drive requests.
  input  wire logic        fw_scl_low,
  input  wire logic        fw_sda_low,
  // Pin ownership and drive; enables are active low.
  output logic             pins_to_port,
  output logic             scl_out,
  output logic             scl_oe_n,
  output logic             sda_out,
  output logic             sda_oe_n,
  // Decoded mode.
  output logic             slave_active,
  output logic             ten_bit_addr,
  output logic             start_stop_irq_en,
  output logic             hw_master,
  output logic             mode_reserved,
  // Interrupt.
  output logic             irq
);
  logic [7:0]           ctrl;
  logic [7:0]           reload;
  logic [7:0]           rx_hold;
  logic                 rx_full;
  logic [SPC_INT_W-1:0] int_status;
  logic [SPC_INT_W-1:0] int_en;
  logic                 acc;
  logic                 wr;
  logic                 rd_rx;
  logic                 mapped;
  logic                 brg_tick;
  logic                 hw_scl;
  logic                 next_scl_low;
  logic                 next_sda_low;
  logic                 is_slave;
  logic                 is_fw;
  logic                 is_hw;
  logic                 enabled;
  logic [3:0]           mode;

  assign acc     = psel && penable;
  assign wr      = acc && pwrite;
  assign rd_rx   = acc && !pwrite && paddr == SPC_RXDATA_OFS;
  assign mapped  = paddr == SPC_CTRL_OFS || paddr == SPC_RELOAD_OFS || paddr == SPC_STATUS_OFS ||
                   paddr == SPC_INT_EN_OFS || paddr == SPC_INT_CLR_OFS || paddr == SPC_RXDATA_OFS;
  assign mode    = ctrl[3:0];
  assign enabled = ctrl[SPC_EN_BIT];

  always_comb
  begin
    is_slave = 1'b0;
    is_fw    = 1'b0;
    is_hw    = 1'b0;
    unique case (mode)
      SPC_MODE_SLV10_SP, SPC_MODE_SLV7_SP, SPC_MODE_SLV7: is_slave = 1'b1;
      SPC_MODE_FW_MST: is_fw = 1'b1;
      SPC_MODE_HW_MST: is_hw = 1'b1;
      default: is_slave = 1'b0;
    endcase
  end

  // Software may only write the low six bits; the overflow flag is cleared by writing zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl <= SPC_CTRL_RESET;
    else
    begin
      if (wr && paddr == SPC_CTRL_OFS)
        ctrl[5:0] <= pwdata[5:0];
      // A new byte over an unread one wins over a software clear.
      if (rx_byte_valid && rx_full && (is_slave || is_fw || is_hw))
        ctrl[SPC_OVF_BIT] <= 1'b1;
      else if (wr && paddr == SPC_CTRL_OFS && !pwdata[SPC_OVF_BIT])
        ctrl[SPC_OVF_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reload <= SPC_RELOAD_RESET;
    else if (wr && paddr == SPC_RELOAD_OFS)
      reload <= pwdata[7:0];
  end

  // The held byte is kept on overflow; the late byte is lost.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_hold <= 8'h00;
      rx_full <= 1'b0;
    end
    else if (rx_byte_valid && !rx_full)
    begin
      rx_hold <= rx_byte;
      rx_full <= 1'b1;
    end
    else if (rd_rx)
      rx_full <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      int_en <= '0;
    else if (wr && paddr == SPC_INT_EN_OFS)
      int_en <= pwdata[SPC_INT_W-1:0];
  end

  // Start and stop events share the receive interrupt only in the modes that ask for them.
  generate
    for (genvar i = 0; i < SPC_INT_W; i++)
    begin : g_int
      logic ev;
      if (i == SPC_INT_RX)
        assign ev = rx_byte_valid || (start_stop_irq_en && (start_seen || stop_seen));
      else
        assign ev = rx_byte_valid && rx_full;
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          int_status[i] <= 1'b0;
        else if (ev)
          int_status[i] <= 1'b1;
        else if (wr && paddr == SPC_INT_CLR_OFS && pwdata[i])
          int_status[i] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(int_status & int_en);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          SPC_CTRL_OFS:   prdata <= {24'h000000, ctrl};
          SPC_RELOAD_OFS: prdata <= {24'h000000, reload};
          SPC_STATUS_OFS: prdata <= {30'h0, int_status};
          SPC_INT_EN_OFS: prdata <= {30'h0, int_en};
          SPC_RXDATA_OFS: prdata <= {24'h000000, rx_hold};
          default:        prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  spc_divider u_div
  (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (enabled && is_hw),
    .reload (reload),
    .tick   (brg_tick)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hw_scl <= 1'b1;
    else if (!(enabled && is_hw))
      hw_scl <= 1'b1;
    else if (brg_tick)
      hw_scl <= !hw_scl;
  end

  // Drive only pulls low; the line is released otherwise, as on any open-drain bus.
  always_comb
  begin
    next_scl_low = 1'b0;
    next_sda_low = 1'b0;
    if (enabled)
    begin
      if (is_slave)
        next_scl_low = !ctrl[SPC_REL_BIT];
      else if (is_fw)
      begin
        next_scl_low = fw_scl_low;
        next_sda_low = fw_sda_low;
      end
      else if (is_hw)
      begin
        next_scl_low = !hw_scl;
        next_sda_low = fw_sda_low;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_to_port      <= 1'b1;
      scl_out           <= 1'b0;
      sda_out           <= 1'b0;
      scl_oe_n          <= 1'b1;
      sda_oe_n          <= 1'b1;
      slave_active      <= 1'b0;
      ten_bit_addr      <= 1'b0;
      start_stop_irq_en <= 1'b0;
      hw_master         <= 1'b0;
      mode_reserved     <= 1'b1;
    end
    else
    begin
      pins_to_port      <= !enabled;
      scl_out           <= 1'b0;
      sda_out           <= 1'b0;
      scl_oe_n          <= !next_scl_low;
      sda_oe_n          <= !next_sda_low;
      slave_active      <= enabled && is_slave;
      ten_bit_addr      <= mode == SPC_MODE_SLV10_SP;
      start_stop_irq_en <= enabled && (mode == SPC_MODE_SLV10_SP || mode == SPC_MODE_SLV7_SP);
      hw_master         <= enabled && is_hw;
      mode_reserved     <= !(is_slave || is_fw || is_hw);
    end
  end

  slave_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && is_slave && !ctrl[SPC_REL_BIT]) |=> !scl_oe_n)
    else $error("slave clock not held low");
  reserved_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(is_slave || is_fw || is_hw) |=> (scl_oe_n && sda_oe_n && mode_reserved))
    else $error("reserved mode drives bus");
  disabled_port_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enabled |=> (pins_to_port && scl_oe_n && sda_oe_n))
    else $error("disabled port still owns pins");
  overflow_set_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_byte_valid && rx_full && !mode_reserved && (is_slave || is_fw || is_hw)) |=> ctrl[SPC_OVF_BIT])
    else $error("overflow not flagged");
  overflow_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl[SPC_OVF_BIT] && !(wr && paddr == SPC_CTRL_OFS)) |=> ctrl[SPC_OVF_BIT])
    else $error("overflow cleared without software");
  ss_irq_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && mode == SPC_MODE_SLV7_SP) |=> (start_stop_irq_en && !ten_bit_addr && slave_active))
    else $error("start stop interrupt mode wrong");
  plain_slave_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && mode == SPC_MODE_SLV7) |=> (!start_stop_irq_en && slave_active))
    else $error("plain slave mode wrong");
  hw_clock_a: assert property (@(posedge clk) disable iff (!rst_n)
    (enabled && is_hw && reload == 8'h00 && $stable(reload) && brg_tick) |=>
      !brg_tick ##1 (brg_tick || !(enabled && is_hw) || reload != 8'h00))
    else $error("bus clock divider period wrong");
endmodule
`default_nettype wire

/* File: spc_pkg.sv */
`default_nettype none
package spc_pkg;
  localparam logic [11:0] SPC_CTRL_OFS     = 12'h000;
  localparam logic [11:0] SPC_RELOAD_OFS   = 12'h004;
  localparam logic [11:0] SPC_STATUS_OFS   = 12'h008;
  localparam logic [11:0] SPC_INT_EN_OFS   = 12'h00c;
  localparam logic [11:0] SPC_INT_CLR_OFS  = 12'h010;
  localparam logic [11:0] SPC_RXDATA_OFS   = 12'h014;
  localparam int          SPC_OVF_BIT      = 6;
  localparam int          SPC_EN_BIT       = 5;
  localparam int          SPC_REL_BIT      = 4;
  localparam logic [7:0]  SPC_CTRL_RESET   = 8'h00;
  localparam logic [7:0]  SPC_CTRL_WMASK   = 8'h3f;
  localparam logic [7:0]  SPC_RELOAD_RESET = 8'h00;
  localparam int          SPC_INT_W        = 2;
  localparam int          SPC_INT_RX       = 0;
  localparam int          SPC_INT_OVF      = 1;
  localparam int          SPC_BRG_MUL      = 4;
  typedef enum logic [3:0]
  {
    SPC_MODE_SLV10_SP = 4'hf,
    SPC_MODE_SLV7_SP  = 4'he,
    SPC_MODE_FW_MST   = 4'hb,
    SPC_MODE_HW_MST   = 4'h8,
    SPC_MODE_SLV7     = 4'h7
  } spc_mode_t;
endpackage
`default_nettype wire

/* File: spc_divider.sv */
`default_nettype none
module spc_divider
  import spc_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control.
  input  wire logic       run,
  input  wire logic [7:0] reload,
  // Enable pulse.
  output logic            tick
);
  // Half period of the bus clock is twice (reload + 1) system cycles.
  logic [9:0] count;
  logic [9:0] limit;

  assign limit = 10'((SPC_BRG_MUL / 2) * (int'(reload) + 1) - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 10'h000;
      tick  <= 1'b0;
    end
    else if (!run)
    begin
      count <= 10'h000;
      tick  <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 10'h000;
      tick  <= 1'b1;
    end
    else
    begin
      count <= count + 10'h001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* File: spc_bus_partner.sv */
`default_nettype none
// Stands in for the bus-side detector that other masters and slaves drive.
module spc_bus_partner
(
  // Clock.
  input  wire logic       clk,
  // Receive path towards the port.
  output logic            rx_byte_valid,
  output logic [7:0]      rx_byte,
  output logic            start_seen,
  output logic            stop_seen
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    rx_byte_valid = 1'b0;
    rx_byte       = 8'h00;
    start_seen    = 1'b0;
    stop_seen     = 1'b0;
  end
  // Outside a byte the data is inverted so that a stale value can never pass.
  task automatic send_byte(input logic [7:0] b);
    @(posedge clk);
    rx_byte_valid <= 1'b1;
    rx_byte       <= b;
    @(posedge clk);
    rx_byte_valid <= 1'b0;
    rx_byte       <= ~b;
  endtask
  task automatic send_mark();
    @(posedge clk);
    start_seen <= 1'b1;
    @(posedge clk);
    start_seen <= 1'b0;
    stop_seen  <= 1'b1;
    @(posedge clk);
    stop_seen  <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: i2c_port_control_register_test.sv */
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; $display("wrong value %s exp %0h got %0h", n, e, g); end end
module i2c_port_control_register_test
  import spc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fw_scl_low = 0, fw_sda_low = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, seed = 32'h61;
  logic        pready, pslverr, rx_byte_valid, start_seen, stop_seen, pins_to_port, scl_out, scl_oe_n;
  logic        sda_out, sda_oe_n, slave_active, ten_bit_addr, start_stop_irq_en, hw_master, mode_reserved, irq;
  logic [7:0]  rx_byte, b;
  logic [32:0] exp_q[$], note;
  logic [3:0]  modes[7] = '{4'hf, 4'he, 4'hb, 4'h8, 4'h7, 4'h6, 4'h0};
  logic [4:0]  dec[7] = '{5'h1c, 5'h14, 5'h00, 5'h02, 5'h10, 5'h01, 5'h01};
  int          mismatches = 0, comparisons = 0, c;
  always #2.5 clk = ~clk;
  spc_ctrl spc_ctrl_inst(.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_byte_valid, .rx_byte, .start_seen, .stop_seen, .fw_scl_low, .fw_sda_low, .pins_to_port, .scl_out,
    .scl_oe_n, .sda_out, .sda_oe_n, .slave_active, .ten_bit_addr, .start_stop_irq_en, .hw_master,
    .mode_reserved, .irq);
  spc_bus_partner spc_bus_partner_inst(.clk, .rx_byte_valid, .rx_byte, .start_seen, .stop_seen);
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      mismatches++;
      test_done();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Counts cycles until the clock enable changes; bounded so a stuck line ends the run.
  task automatic edge_gap(output int n);
    logic p;
    p = scl_oe_n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (scl_oe_n === p && n < 100);
    if (scl_oe_n === p)
    begin
      mismatches++;
      test_done();
    end
  endtask
  always @(posedge clk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      note = exp_q.pop_front();
      `CHK("read", note, {pslverr, prdata})
    end
  initial
  begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    `CHK("pins", 1'b1, pins_to_port)
    `CHK("pins idle", 2'b11, {scl_oe_n, sda_oe_n})
    rd(SPC_CTRL_OFS, 32'h0);
    rd(12'h018, 32'h0, 1'b1);
    for (int i = 0; i < 7; i++)
    begin
      apb(1'b1, SPC_CTRL_OFS, {24'h0, 4'h3, modes[i]});
      settle();
      `CHK("mode", dec[i], {slave_active, ten_bit_addr, start_stop_irq_en, hw_master, mode_reserved})
    end
    @(posedge clk);
    fw_scl_low <= 1'b1;
    fw_sda_low <= 1'b1;
    settle();
    `CHK("reserved", 2'b11, {scl_oe_n, sda_oe_n})
    apb(1'b1, SPC_CTRL_OFS, 32'h3b);
    settle();
    `CHK("fw drive", 3'b000, {pins_to_port, scl_oe_n, sda_oe_n})
    `CHK("line levels", 2'b00, {scl_out, sda_out})
    apb(1'b1, SPC_CTRL_OFS, 32'h1b);
    settle();
    `CHK("disabled", 3'b111, {pins_to_port, scl_oe_n, sda_oe_n})
    @(posedge clk);
    fw_scl_low <= 1'b0;
    fw_sda_low <= 1'b0;
    apb(1'b1, SPC_CTRL_OFS, 32'h2e);
    settle();
    `CHK("stretch", 1'b0, scl_oe_n)
    apb(1'b1, SPC_CTRL_OFS, 32'h3e);
    settle();
    `CHK("release", 1'b1, scl_oe_n)
    spc_bus_partner_inst.send_mark();
    settle();
    rd(SPC_STATUS_OFS, 32'h1);
    apb(1'b1, SPC_INT_CLR_OFS, 32'h3);
    apb(1'b1, SPC_CTRL_OFS, 32'h37);
    spc_bus_partner_inst.send_mark();
    settle();
    rd(SPC_STATUS_OFS, 32'h0);
    seed = xorshift(seed);
    b = seed[7:0];
    spc_bus_partner_inst.send_byte(b);
    spc_bus_partner_inst.send_byte(~b);
    settle();
    rd(SPC_CTRL_OFS, 32'h77);
    rd(SPC_STATUS_OFS, 32'h3);
    apb(1'b1, SPC_INT_EN_OFS, 32'h2);
    settle();
    `CHK("irq", 1'b1, irq)
    apb(1'b1, SPC_INT_EN_OFS, 32'h0);
    settle();
    `CHK("irq masked", 1'b0, irq)
    apb(1'b1, SPC_INT_EN_OFS, 32'h2);
    rd(SPC_RXDATA_OFS, {24'h0, b});
    apb(1'b1, SPC_INT_CLR_OFS, 32'h2);
    settle();
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, SPC_CTRL_OFS, 32'h37);
    rd(SPC_CTRL_OFS, 32'h37);
    seed = xorshift(seed);
    apb(1'b1, SPC_CTRL_OFS, 32'h28);
    // Reload zero runs first so that the shortest divider period is exercised as well.
    for (int k = 0; k < 2; k++)
    begin
      apb(1'b1, SPC_RELOAD_OFS, k * {29'h0, seed[2:0]});
      // A period begun under the old reload may still be in flight, so it is skipped.
      repeat (3) edge_gap(c);
      `CHK("scl half period", 2 * (k * seed[2:0] + 1), c)
    end
    settle();
    test_done();
  end
endmodule
`default_nettype wire
